//--- verif/dac_model.sv
`timescale 1ns/100ps
module dac_model (
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   input  wire sine_synth_pkg::sample_type sample,
   input  wire logic                     sample_valid,
   input  wire logic                     hold,
   output logic                          sample_ready
);
   import sine_synth_pkg::*;
   sample_type got_q[$];

   // Converter takes a word at each valid and ready edge; hold makes it a stalled consumer
   always @(posedge clock) begin
      if (rst_b && sample_valid && sample_ready) begin
         got_q.push_back(sample);
      end
      sample_ready <= ~hold;
   end

   initial sample_ready = 1'b0;
endmodule

//--- verif/sine_synth_tb_top.sv
`timescale 1ns/100ps
module sine_synth_tb_top;
   import sine_synth_pkg::*;
   logic          clock      = 1'b0;
   logic          rst_b      = 1'b0;
   logic [17:0]   tuning     = 18'h00000;
   logic          table_wr   = 1'b0;
   logic [3:0]    table_addr = 4'h0;
   logic [7:0]    table_data = 8'h00;
   logic          hold       = 1'b0;
   sample_type    sample;
   logic          sample_valid;
   logic          sample_ready;
   logic          sample_stall;
   int            error_cnt       = 0;
   int            samples_checked = 0;
   magnitude_type tbl [16];

   always #2 clock = ~clock;

   sine_synth dut_u (.clock(clock), .rst_b(rst_b), .tuning(tuning), .table_wr(table_wr),
      .table_addr(table_addr), .table_data(table_data), .sample(sample),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_stall(sample_stall));
   dac_model dac_u (.clock(clock), .rst_b(rst_b), .sample(sample),
      .sample_valid(sample_valid), .hold(hold), .sample_ready(sample_ready));

   // Sign from top phase bit, magnitude inverted when it is set
   function automatic sample_type exp_word(input phase_type acc);
      logic [5:0]    ph;
      magnitude_type m;
      ph = acc[21:16];
      m = tbl[ph[3:0] ^ {4{ph[4]}}];
      return {ph[5], m ^ {8{ph[5]}}};
   endfunction

   task automatic cmp_word(input string what, input sample_type exp, input sample_type got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_flag(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic close_out();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Table is not cleared by reset, so a reload survives the restarts below
   task automatic write_entry(input logic [3:0] a, input magnitude_type d);
      @(posedge clock);
      table_wr <= 1'b1;
      table_addr <= a;
      table_data <= d;
      tbl[a] = d;
   endtask

   task automatic restart(input logic [17:0] k, input logic h);
      @(posedge clock);
      rst_b <= 1'b0;
      tuning <= k;
      hold <= h;
      repeat (2) @(posedge clock);
      dac_u.got_q.delete();
      cmp_flag("valid in reset", 1'b0, sample_valid);
      rst_b <= 1'b1;
   endtask

   // Word i of a run must come from phase i*k, wrapping at 22 bits
   task automatic run_tone(input logic [17:0] k, input int n);
      int i;
      restart(k, 1'b0);
      for (i = 0; i < n + 20 && dac_u.got_q.size() < n; i++) @(posedge clock);
      cmp_flag("word count", 1'b1, dac_u.got_q.size() >= n);
      for (i = 0; i < n && i < dac_u.got_q.size(); i++) begin
         cmp_word("sample", exp_word(phase_type'(i * k)), dac_u.got_q[i]);
      end
   endtask

   // Stalled consumer: the oldest nine words survive (output register plus eight in the FIFO), later ones are dropped
   task automatic overflow_drop();
      int i;
      restart(18'h10000, 1'b1);
      repeat (24) @(posedge clock);
      cmp_flag("sample_stall", 1'b1, sample_stall);
      cmp_word("held sample", exp_word(22'h0), sample);
      hold <= 1'b0;
      for (i = 0; i < 40 && dac_u.got_q.size() < 8; i++) @(posedge clock);
      for (i = 0; i < 8 && i < dac_u.got_q.size(); i++) begin
         cmp_word("kept sample", exp_word(phase_type'(i * 32'h10000)), dac_u.got_q[i]);
      end
   endtask

   // Rewriting the table in mid-run shows in the stream without a restart
   task automatic live_rewrite();
      run_tone(18'h00000, 8);
      write_entry(4'h0, 8'hc3);
      @(posedge clock);
      table_wr <= 1'b0;
      repeat (12) @(posedge clock);
      cmp_word("rewritten", 9'h0c3, dac_u.got_q[$]);
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      close_out();
   end

   initial begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      for (int i = 0; i < 16; i++) write_entry(4'(i), {4'(i), ~4'(i)});
      @(posedge clock);
      table_wr <= 1'b0;
      run_tone(18'h10000, 66);
      run_tone(18'h3ffff, 40);
      run_tone(18'h00001, 8);
      overflow_drop();
      live_rewrite();
      close_out();
   end
endmodule

//--- verilog/sample_fifo.sv
`timescale 1ns/100ps
module sample_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0]   wr;
      logic [AW:0]   rd;
   } fifo_state_type;

   fifo_state_type      st_q;
   fifo_state_type      st_d;
   logic [WIDTH-1:0]    mem [DEPTH];
   logic                push;
   logic                pop;
   logic [AW:0]         count;

   // Occupancy from pointer difference; extra bit separates full from empty
   assign count     = st_q.wr - st_q.rd;
   assign in_ready  = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign out_data  = mem[st_q.rd[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer advance
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wr = st_q.wr + 1'b1;
      end
      if (pop) begin
         st_d.rd = st_q.rd + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Storage has no reset; empty flag hides stale words
   always_ff @(posedge clock) begin
      if (push) begin
         mem[st_q.wr[AW-1:0]] <= in_data;
      end
   end
endmodule

//--- verilog/sine_synth.sv
`timescale 1ns/100ps
`include "sine_synth_defines.svh"

module sine_synth
   import sine_synth_pkg::*;
#(
   parameter int LOW_BITS  = `LOW_BITS,
   parameter int TOP_BITS  = `TOP_BITS,
   parameter int QA_BITS   = `QUAD_ADDR_BITS,
   parameter int MAG_BITS  = `MAG_BITS,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input  wire logic                clock,
   input  wire logic                rst_b,
   input  wire logic [LOW_BITS-1:0] tuning,
   input  wire logic                table_wr,
   input  wire logic [QA_BITS-1:0]  table_addr,
   input  wire logic [MAG_BITS-1:0] table_data,
   output logic      [MAG_BITS:0]   sample,
   output logic                     sample_valid,
   input  wire logic                sample_ready,
   output logic                     sample_stall
);
   import sine_synth_pkg::*;

   localparam int ACC_W   = LOW_BITS + TOP_BITS;
   localparam int PH_W    = QA_BITS + 2;
   localparam int ENTRIES = 1 << QA_BITS;
   localparam int SW      = MAG_BITS + 1;

   typedef struct packed {
      logic [LOW_BITS-1:0] low;
      logic [TOP_BITS-1:0] top;
      logic [SW-1:0]       word;
      logic                word_valid;
      logic [SW-1:0]       out;
      logic                out_valid;
      logic                stall;
   } synth_state_type;

   synth_state_type    st_q;
   synth_state_type    st_d;
   logic [MAG_BITS-1:0] quarter [ENTRIES];
   logic [LOW_BITS:0]  low_sum;
   logic [ACC_W-1:0]   acc;
   logic [PH_W-1:0]    phase;
   logic [MAG_BITS-1:0] signed_mag;
   logic [QA_BITS-1:0] qaddr;
   logic [MAG_BITS-1:0] mag;
   logic               fifo_in_ready;
   logic [SW-1:0]      fifo_data;
   logic               fifo_valid;
   logic               fifo_pop;

   // Default quarter-sine magnitudes, sampled at the middle of each step
   function automatic logic [MAG_BITS-1:0] sine_init(input int idx);
      real ang;
      ang = (idx + 0.5) * 1.5707963267948966 / ENTRIES;
      return MAG_BITS'($rtoi($sin(ang) * ((1 << MAG_BITS) - 1) + 0.5));
   endfunction

   // Quadrant fold of the within-quadrant address
   function automatic logic [QA_BITS-1:0] fold_addr(input logic [PH_W-1:0] ph);
      return ph[QA_BITS-1:0] ^ {QA_BITS{ph[PH_W-2]}};
   endfunction

   // Table loads with a sine at start-up; writes replace any entry live
   // quarter-period table
   initial begin
      for (int i = 0; i < ENTRIES; i++) begin
         quarter[i] = sine_init(i);
      end
   end
   // Plain always: the start-up load above also writes this array
   always @(posedge clock) begin
      if (table_wr) begin
         quarter[table_addr] <= table_data;
      end
   end

   // Phase field and table read
   // six top phase bits
   assign low_sum = {1'b0, st_q.low} + {1'b0, tuning};
   assign acc     = {st_q.top, st_q.low};
   assign phase   = acc[ACC_W-1 -: PH_W];
   assign qaddr   = fold_addr(phase);
   assign mag     = quarter[qaddr];

   // Sign XOR per magnitude plane; the plane count follows MAG_BITS
   // per-plane sign XOR
   for (genvar b = 0; b < MAG_BITS; b++) begin : g_plane
      assign signed_mag[b] = mag[b] ^ phase[PH_W-1];
   end

   // Next state: accumulator, sample pipeline, hand-off to the FIFO
   always_comb begin
      st_d = st_q;
      st_d.low = low_sum[LOW_BITS-1:0];
      if (low_sum[LOW_BITS]) begin
         st_d.top = st_q.top + 1'b1;
      end
      st_d.word = {phase[PH_W-1], signed_mag};
      st_d.word_valid = 1'b1;
      // A full FIFO drops the newest sample rather than freezing phase
      st_d.stall = !fifo_in_ready;
      if (fifo_pop) begin
         st_d.out = fifo_data;
         st_d.out_valid = 1'b1;
      end else if (sample_ready) begin
         st_d.out_valid = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Output stage pulls a new word when empty or consumed
   assign fifo_pop = fifo_valid && (!st_q.out_valid || sample_ready);

   sample_fifo #(
      .WIDTH (SW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .in_data   (st_q.word),
      .in_valid  (st_q.word_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   assign sample       = st_q.out;
   assign sample_valid = st_q.out_valid;
   assign sample_stall = st_q.stall;

   // Accumulator and sample checks
   AST_LOW_ADD: assert property (@(posedge clock) disable iff (!rst_b)
      $past(rst_b) |-> st_q.low == LOW_BITS'($past(st_q.low) + $past(tuning)))
      else $error("low accumulator did not add tuning");
   AST_TOP_CARRY: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && !$past(low_sum[LOW_BITS])) |-> $stable(st_q.top))
      else $error("top counter moved without carry");
   AST_TOP_STEP: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && $past(low_sum[LOW_BITS]))
      |-> st_q.top == TOP_BITS'($past(st_q.top) + 1))
      else $error("top counter missed a carry");
   AST_SIGN: assert property (@(posedge clock) disable iff (!rst_b)
      $past(rst_b) |-> st_q.word[SW-1] == $past(phase[PH_W-1]))
      else $error("sign bit not from top phase bit");
   AST_MAG: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && !$past(table_wr)) |->
      st_q.word[MAG_BITS-1:0] == ($past(mag) ^ {MAG_BITS{$past(phase[PH_W-1])}}))
      else $error("magnitude not XORed with sign");
   AST_FOLD: assert property (@(posedge clock) disable iff (!rst_b)
      phase[PH_W-2] |-> qaddr == ~phase[QA_BITS-1:0])
      else $error("address not reversed");
   AST_RESET: assert property (@(posedge clock)
      !rst_b |=> (st_q.low == '0 && st_q.top == '0 && !sample_valid))
      else $error("reset did not clear");
   AST_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
      (sample_valid && !sample_ready) |=> ($stable(sample) && sample_valid))
      else $error("sample changed while stalled");
   AST_TABLE: assert property (@(posedge clock) disable iff (!rst_b)
      table_wr |=> quarter[$past(table_addr)] == $past(table_data))
      else $error("table write lost");

   // Top counter wraps to zero after all ones
   AST_TOP_WRAP: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && $past(low_sum[LOW_BITS]) && $past(&st_q.top))
      |-> st_q.top == '0)
      else $error("top counter did not wrap");
   // A carry always leaves the low part below its old value
   AST_CARRY_LOW: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && $past(low_sum[LOW_BITS]))
      |-> st_q.low < $past(st_q.low))
      else $error("carry without low wrap");
   // Without a carry the low part never falls, so no phase jump
   AST_NO_JUMP: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && !$past(low_sum[LOW_BITS]))
      |-> st_q.low >= $past(st_q.low))
      else $error("low part fell without carry");
   // Zero tuning freezes the phase
   AST_STILL: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && $past(tuning) == '0) |-> $stable(phase))
      else $error("phase moved with zero tuning");
   // Top phase bits are the carry counter itself
   AST_PHASE_TOP: assert property (@(posedge clock) disable iff (!rst_b)
      phase[PH_W-1 -: TOP_BITS] == st_q.top)
      else $error("phase field not from top bits");
   // Any tuning word moves at most four table steps per clock
   AST_RATE: assert property (@(posedge clock) disable iff (!rst_b)
      $past(rst_b) |-> (PH_W'(phase - $past(phase)) <= PH_W'(4)))
      else $error("too few look-ups per period");
   // First and third quarters read the table in forward order
   AST_FOLD_PASS: assert property (@(posedge clock) disable iff (!rst_b)
      !phase[PH_W-2] |-> qaddr == phase[QA_BITS-1:0])
      else $error("address reversed in forward quarter");
   // Positive half passes the table word unchanged
   AST_POS_PASS: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && !$past(phase[PH_W-1]))
      |-> st_q.word[MAG_BITS-1:0] == $past(mag))
      else $error("positive half altered");
   // Negative half inverts every magnitude plane
   AST_NEG_INV: assert property (@(posedge clock) disable iff (!rst_b)
      ($past(rst_b) && $past(phase[PH_W-1]))
      |-> st_q.word[MAG_BITS-1:0] == ~$past(mag))
      else $error("negative half not inverted");
   // One look-up is issued on every clock out of reset
   AST_WORD_EVERY: assert property (@(posedge clock) disable iff (!rst_b)
      $past(rst_b) |-> st_q.word_valid)
      else $error("look-up skipped");
   // Reset also empties the sample pipeline and the stall flag
   AST_RESET_PIPE: assert property (@(posedge clock)
      !rst_b |=> (!st_q.word_valid && !sample_stall))
      else $error("pipeline not cleared by reset");
   // A full FIFO is flagged on the next edge
   AST_STALL_SET: assert property (@(posedge clock) disable iff (!rst_b)
      !fifo_in_ready |=> sample_stall)
      else $error("drop not flagged");
   AST_STALL_CLR: assert property (@(posedge clock) disable iff (!rst_b)
      fifo_in_ready |=> !sample_stall)
      else $error("stall flag stuck");
   // Output register loads the FIFO head when it pops
   AST_POP_LOAD: assert property (@(posedge clock) disable iff (!rst_b)
      fifo_pop |=> (sample_valid && sample == $past(fifo_data)))
      else $error("popped word not presented");
   // Accepted word with nothing behind it leaves the output empty
   AST_DRAIN: assert property (@(posedge clock) disable iff (!rst_b)
      (sample_valid && sample_ready && !fifo_valid) |=> !sample_valid)
      else $error("stale sample repeated");

   COV_REVERSE: cover property (@(posedge clock) disable iff (!rst_b)
      phase[PH_W-2] && !phase[PH_W-1]);
   COV_WRAP: cover property (@(posedge clock) disable iff (!rst_b) low_sum[LOW_BITS]);
   COV_NEG: cover property (@(posedge clock) disable iff (!rst_b) sample_valid && sample[SW-1]);
   COV_STALL: cover property (@(posedge clock) disable iff (!rst_b) sample_stall);
   COV_WRITE: cover property (@(posedge clock) disable iff (!rst_b) table_wr ##1 sample_valid);
endmodule

//--- verilog/sine_synth_defines.svh
`ifndef SINE_SYNTH_DEFINES_SVH
`define SINE_SYNTH_DEFINES_SVH

// Accumulator geometry
`define LOW_BITS        18
`define TOP_BITS        4
`define ACC_BITS        22
`define PHASE_BITS      6
`define QUAD_ADDR_BITS  4
`define MAG_BITS        8
`define SAMPLE_BITS     9
`define FIFO_DEPTH      8
// Field positions inside the six-bit phase field
`define SIGN_POS        5
`define REVERSE_POS     4
// Reset values
`define ACC_RESET       22'h000000
`define SAMPLE_RESET    9'h000
// Clock rate in Hz (2^22)
`define CLOCK_HZ        4194304

`endif

//--- verilog/sine_synth_pkg.sv
package sine_synth_pkg;
   typedef logic [21:0] phase_type;
   typedef logic [8:0]  sample_type;
   typedef logic [7:0]  magnitude_type;
endpackage
